// File: core/eps_pkg.sv
/*
 * Constants for the two-wire memory slave pin block: timing figures,
 * derived cycle counts, speed classes and the protocol state encoding.
 * Assumes a 125 MHz system clock (ref_clk, 8 ns period).
 */
package eps_pkg;

    // ****************************************************************
    // clock and timing
    // ****************************************************************
    localparam int CLK_PERIOD_PS          = 8000;
    localparam int NOISE_FILTER_WIDTH_NS  = 100;  // standard and fast
    localparam int NOISE_FILTER_FP_NS     = 50;   // fast-plus
    localparam int POWERUP_READY_DELAY_US = 1000; // 1 ms
    localparam int INTERNAL_WRITE_TIME_US = 5000; // 5 ms

    // longest time rounds down, least one cycle
    localparam int NOISE_FILTER_CYC =
        (NOISE_FILTER_WIDTH_NS * 1000 / CLK_PERIOD_PS) + 1;
    localparam int NOISE_FILTER_FP_CYC =
        (NOISE_FILTER_FP_NS * 1000 / CLK_PERIOD_PS) + 1;
    localparam int POWERUP_READY_CYC =
        POWERUP_READY_DELAY_US * 1000 / (CLK_PERIOD_PS / 1000);
    localparam int INTERNAL_WRITE_CYC =
        INTERNAL_WRITE_TIME_US * 1000 / (CLK_PERIOD_PS / 1000);

    localparam int FILT_W = 5;
    localparam int WAIT_W = 20;

    // ****************************************************************
    // protocol fields
    // ****************************************************************
    localparam logic [3:0] DEV_TYPE_CODE = 4'h000A; // fixed slave prefix
    localparam int         BIT_CNT_W     = 4;
    localparam logic [3:0] ACK_SLOT      = 4'h0008;
    localparam logic [3:0] BIT_CNT_ZERO  = 4'h0000;

    // ****************************************************************
    // states
    // ****************************************************************
    typedef enum logic [2:0] {
        EPS_RESET   = 3'h0,
        EPS_STANDBY = 3'h1,
        EPS_ADDR    = 3'h3,
        EPS_RXDATA  = 3'h2,
        EPS_TXDATA  = 3'h6,
        EPS_WRITING = 3'h7,
        EPS_IGNORE  = 3'h5
    } eps_state_t;

endpackage : eps_pkg

// File: core/eps_glitch_filter.sv
/*
 * Glitch filter for one bus input: the output follows the input only
 * after it has held a new level for more than the chosen width.
 * Assumes the input is already synchronous to ref_clk.
 */
module eps_glitch_filter #(
    parameter int FILT_W = 5
) (
    input  wire logic              ref_clk,
    input  wire logic              rst,
    input  wire logic              rawIn,
    input  wire logic [FILT_W-1:0] widthCyc,
    output logic                   filtOut
);

    // a one-bit counter cannot hold any useful width
    if (FILT_W < 2) begin : g_badWidth
        $error("FILT_W too small");
    end

    logic [FILT_W-1:0] holdCnt;

    // ****************************************************************
    // count stable cycles of a differing level
    // ****************************************************************
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            holdCnt <= '0;
            filtOut <= 1'b1;
        end else if (rawIn == filtOut) begin
            holdCnt <= '0;
        end else if (holdCnt >= widthCyc) begin
            filtOut <= rawIn;
            holdCnt <= '0;
        end else begin
            holdCnt <= holdCnt + 1'b1;
        end
    end

endmodule : eps_glitch_filter

// File: core/eps_slave_pins.sv
/*
 * Two-wire memory slave, pin behaviour: filtered bus inputs, edge
 * detection, address/data byte handling, open-drain data out,
 * write protect, power-up delay and internal write busy time.
 * Assumes all inputs synchronous to ref_clk; rst stands for power-on
 * reset; memory content is external (wrData/wrStrobe, rdData).
 */
module eps_slave_pins #(
    parameter int POWERUP_CYC = eps_pkg::POWERUP_READY_CYC,
    parameter int WRITE_CYC   = eps_pkg::INTERNAL_WRITE_CYC
) (
    input  wire logic       ref_clk,
    input  wire logic       rst,
    input  wire logic       serialClock,
    input  wire logic       serialDataIn,
    output logic            serialDataOut,
    output logic            serialDataOe_n,
    input  wire logic       device_select_bit0,
    input  wire logic       device_select_bit1,
    input  wire logic       device_select_bit2,
    input  wire logic       writeProtect,
    input  wire logic       fastPlusMode,
    input  wire logic [7:0] rdData,
    output logic [7:0]      wrData,
    output logic            wrStrobe,
    output logic            rdStrobe,
    output logic            ready,
    output logic            writeBusy
);

    // refuse counts the wait counters cannot hold
    if (POWERUP_CYC < 1 || POWERUP_CYC >= (1 << eps_pkg::WAIT_W)) begin : g_badPowerup
        $error("POWERUP_CYC out of range");
    end
    if (WRITE_CYC < 1 || WRITE_CYC >= (1 << eps_pkg::WAIT_W)) begin : g_badWrite
        $error("WRITE_CYC out of range");
    end

    // ****************************************************************
    // input filtering and edges
    // ****************************************************************
    logic                       sclF;
    logic                       sdaF;
    logic                       sclD;
    logic                       sdaD;
    logic [eps_pkg::FILT_W-1:0] filtCyc;

    // fast-plus narrows the rejected pulse width
    assign filtCyc = fastPlusMode ? eps_pkg::FILT_W'(eps_pkg::NOISE_FILTER_FP_CYC)
                                  : eps_pkg::FILT_W'(eps_pkg::NOISE_FILTER_CYC);

    eps_glitch_filter #(.FILT_W(eps_pkg::FILT_W)) u_sclFilt (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .rawIn    (serialClock),
        .widthCyc (filtCyc),
        .filtOut  (sclF)
    );

    eps_glitch_filter #(.FILT_W(eps_pkg::FILT_W)) u_sdaFilt (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .rawIn    (serialDataIn),
        .widthCyc (filtCyc),
        .filtOut  (sdaF)
    );

    // delayed copies for edge detection
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sclD <= 1'b1;
            sdaD <= 1'b1;
        end else begin
            sclD <= sclF;
            sdaD <= sdaF;
        end
    end

    logic sclRise;
    logic sclFall;
    logic startCond;
    logic stopCond;

    assign sclRise   = sclF & ~sclD;
    assign sclFall   = ~sclF & sclD;
    assign startCond = sclF & sclD & sdaD & ~sdaF;
    assign stopCond  = sclF & sclD & ~sdaD & sdaF;

    // ****************************************************************
    // power-up and write cycle timers
    // ****************************************************************
    logic [eps_pkg::WAIT_W-1:0] puCnt;
    logic [eps_pkg::WAIT_W-1:0] wrCnt;
    logic                       wrPending;

    // ready after the power-up delay
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            puCnt <= '0;
            ready <= 1'b0;
        end else if (!ready) begin
            if (puCnt == eps_pkg::WAIT_W'(POWERUP_CYC - 1)) begin
                ready <= 1'b1;
            end else begin
                puCnt <= puCnt + 1'b1;
            end
        end
    end

    // internal write cycle; started by stop after accepted data
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wrCnt     <= '0;
            writeBusy <= 1'b0;
        end else if (writeBusy) begin
            if (wrCnt == eps_pkg::WAIT_W'(WRITE_CYC - 1)) begin
                writeBusy <= 1'b0;
                wrCnt     <= '0;
            end else begin
                wrCnt <= wrCnt + 1'b1;
            end
        end else if (stopCond && wrPending) begin
            writeBusy <= 1'b1;
        end
    end

    // ****************************************************************
    // byte protocol
    // ****************************************************************
    eps_pkg::eps_state_t           state;
    logic [eps_pkg::BIT_CNT_W-1:0] bitCnt;
    logic [7:0]                    shiftIn;
    logic [7:0]                    shiftOut;
    logic [1:0]                    addrBytes;
    logic                          ackNow;
    logic                          wpLatched;
    logic                          addrMatch;
    logic [7:0]                    rxByte;

    assign rxByte    = {shiftIn[6:0], sdaF};
    // full byte is in shiftIn once the 8th rise has passed
    // floating selects arrive as low from the pad pull-downs
    assign addrMatch = (shiftIn[7:4] == eps_pkg::DEV_TYPE_CODE)
                     && (shiftIn[3:1] == {device_select_bit2, device_select_bit1,
                                          device_select_bit0});

    // state, bit counter and shift registers
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state     <= eps_pkg::EPS_RESET;
            bitCnt    <= eps_pkg::BIT_CNT_ZERO;
            shiftIn   <= '0;
            shiftOut  <= '0;
            addrBytes <= '0;
            ackNow    <= 1'b0;
            wpLatched <= 1'b0;
            wrPending <= 1'b0;
            wrData    <= '0;
            wrStrobe  <= 1'b0;
            rdStrobe  <= 1'b0;
        end else begin
            wrStrobe <= 1'b0;
            rdStrobe <= 1'b0;
            if (state == eps_pkg::EPS_RESET) begin
                if (ready) begin
                    state <= eps_pkg::EPS_STANDBY;
                end
            end else if (writeBusy) begin
                state  <= eps_pkg::EPS_WRITING;
                ackNow <= 1'b0;
                wrPending <= 1'b0;
            end else if (stopCond) begin
                state  <= eps_pkg::EPS_STANDBY;
                ackNow <= 1'b0;
            end else if (startCond) begin
                state     <= eps_pkg::EPS_ADDR;
                bitCnt    <= eps_pkg::ACK_SLOT;     // fall after start is no data bit
                ackNow    <= 1'b0;
                wrPending <= 1'b0;
            end else if (sclRise && bitCnt != eps_pkg::ACK_SLOT) begin
                shiftIn <= rxByte;
            end else if (sclRise && state == eps_pkg::EPS_TXDATA && sdaF) begin
                state <= eps_pkg::EPS_IGNORE;      // master no-ack ends read
            end else if (sclFall) begin
                // change outgoing data only after the falling edge
                if (bitCnt == eps_pkg::ACK_SLOT) begin
                    bitCnt <= eps_pkg::BIT_CNT_ZERO;
                    ackNow <= 1'b0;
                    if (state == eps_pkg::EPS_TXDATA) begin
                        shiftOut <= rdData;
                        rdStrobe <= 1'b1;
                    end
                end else if (bitCnt == eps_pkg::ACK_SLOT - 1'b1) begin
                    bitCnt <= bitCnt + 1'b1;
                    unique case (state)
                        eps_pkg::EPS_ADDR: begin
                            ackNow    <= addrMatch;
                            addrBytes <= '0;
                            if (!addrMatch) begin
                                state <= eps_pkg::EPS_IGNORE;
                            end else if (shiftIn[0]) begin
                                // first byte loads at the fall ending the ack
                                state <= eps_pkg::EPS_TXDATA;
                            end else begin
                                state <= eps_pkg::EPS_RXDATA;
                            end
                        end
                        eps_pkg::EPS_RXDATA: begin
                            if (addrBytes != 2'h2) begin
                                addrBytes <= addrBytes + 1'b1;
                                ackNow    <= 1'b1;
                                // protect strobed before first data byte
                                if (addrBytes == 2'h1) begin
                                    wpLatched <= writeProtect;
                                end
                            end else if (wpLatched) begin
                                ackNow <= 1'b0;
                                state  <= eps_pkg::EPS_IGNORE;
                            end else begin
                                ackNow    <= 1'b1;
                                wrData    <= shiftIn;
                                wrStrobe  <= 1'b1;
                                wrPending <= 1'b1;
                            end
                        end
                        default: begin
                            ackNow <= 1'b0;
                        end
                    endcase
                end else begin
                    bitCnt <= bitCnt + 1'b1;
                    if (state == eps_pkg::EPS_TXDATA) begin
                        shiftOut <= {shiftOut[6:0], 1'b1};
                    end
                end
            end
        end
    end

    // ****************************************************************
    // open-drain data output
    // ****************************************************************
    logic next_driveLow;

    always_comb begin
        next_driveLow = 1'b0;
        if (state == eps_pkg::EPS_TXDATA && bitCnt != eps_pkg::ACK_SLOT) begin
            next_driveLow = ~shiftOut[7];
        end else if (ackNow) begin
            next_driveLow = 1'b1;
        end
        if (writeBusy || state == eps_pkg::EPS_RESET) begin
            next_driveLow = 1'b0;
        end
    end

    // enable low while pulling the line low; data always zero
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            serialDataOut  <= 1'b0;
            serialDataOe_n <= 1'b1;
        end else begin
            serialDataOut  <= 1'b0;
            serialDataOe_n <= ~next_driveLow;
        end
    end

endmodule : eps_slave_pins

// File: bench/eps_slave_pins_sva.sv
/* port assertions for the two-wire slave pin block.
   assumes every port is synchronous to ref_clk */
module eps_slave_pins_sva #(
    parameter int POWERUP_CYC = 50,
    parameter int WRITE_CYC   = 100
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic serialClock,
    input wire logic serialDataIn,
    input wire logic serialDataOut,
    input wire logic serialDataOe_n,
    input wire logic writeProtect,
    input wire logic wrStrobe,
    input wire logic ready,
    input wire logic writeBusy
);
    timeunit 1ns;
    timeprecision 1ps;
    int upCnt;
    int busyCnt;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    // cycles spent waiting for ready
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) upCnt <= 0;
        else if (!ready) upCnt <= upCnt + 1;
    end
    // length of the running write cycle
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) busyCnt <= 0;
        else busyCnt <= writeBusy ? busyCnt + 1 : 0;
    end
    AST_OPEN_DRAIN: assert property (!serialDataOut)
        else $error("data out drives high");
    AST_OE_AFTER_FALL: assert property ($changed(serialDataOe_n) |-> !serialClock)
        else $error("data changed while clock high");
    AST_RESET_STATE: assert property (disable iff (1'b0)
        rst && $past(rst) |-> serialDataOe_n && !ready && !writeBusy)
        else $error("not in reset state");
    AST_READY_LATE: assert property (upCnt <= POWERUP_CYC + 3)
        else $error("ready too late");
    AST_READY_EARLY: assert property ($rose(ready) |-> upCnt >= POWERUP_CYC - 2
        ##1 ready [*8]) else $error("ready too early or dropped");
    AST_QUIET_UNREADY: assert property (!ready |-> serialDataOe_n)
        else $error("answer before ready");
    AST_BUSY_QUIET: assert property (writeBusy |-> serialDataOe_n)
        else $error("data driven while busy");
    AST_BUSY_AFTER_STOP: assert property ($rose(writeBusy) |->
        serialClock && serialDataIn ##1 writeBusy [*8]) else $error("bad write start");
    AST_BUSY_LEN: assert property ($fell(writeBusy) |-> busyCnt >= WRITE_CYC - 2)
        else $error("write cycle short");
    AST_BUSY_BOUND: assert property (busyCnt <= WRITE_CYC + 2)
        else $error("write cycle long");
    AST_PROTECT: assert property (writeProtect |-> !wrStrobe)
        else $error("write while protected");
endmodule : eps_slave_pins_sva

bind eps_slave_pins eps_slave_pins_sva #(.POWERUP_CYC(POWERUP_CYC), .WRITE_CYC(WRITE_CYC)) uSva (
    .ref_clk(ref_clk), .rst(rst), .serialClock(serialClock), .serialDataIn(serialDataIn),
    .serialDataOut(serialDataOut), .serialDataOe_n(serialDataOe_n),
    .writeProtect(writeProtect), .wrStrobe(wrStrobe), .ready(ready), .writeBusy(writeBusy));

// File: bench/eps_bus_master.sv
/* two-wire bus master model: makes every clock pulse, frames bytes.
   assumes busSda is the wired-and data level with pull-up */
module eps_bus_master (
    input  wire logic ref_clk,
    input  wire logic busSda,
    output logic      scl,
    output logic      sdaDrive
);
    timeunit 1ns;
    timeprecision 1ps;
    int halfCyc = 160;
    // idle bus, both released
    initial begin
        scl = 1'b1;
        sdaDrive = 1'b1;
    end
    task automatic hold(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : hold
    // start from idle
    task automatic start();
        hold(8);
        sdaDrive <= 1'b1;
        hold(8);
        scl <= 1'b1;
        hold(halfCyc);
        sdaDrive <= 1'b0;
        hold(halfCyc);
        scl <= 1'b0;
    endtask : start
    // one clock, optional low glitch mid high
    task automatic bitCyc(input logic b, input int glitch, output logic r);
        hold(8);
        sdaDrive <= b;
        hold(halfCyc);
        scl <= 1'b1;
        hold(halfCyc / 2);
        r = busSda;
        if (glitch > 0) begin
            scl <= 1'b0;
            hold(glitch);
            scl <= 1'b1;
        end
        hold(halfCyc / 2);
        scl <= 1'b0;
    endtask : bitCyc
    task automatic sendByte(input logic [7:0] b, input int glitch, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bitCyc(b[i], (i == 4) ? glitch : 0, r);
        bitCyc(1'b1, 0, r);
        ack = !r;
    endtask : sendByte
    task automatic readByte(input logic ackIt, output logic [7:0] d);
        logic r;
        for (int i = 0; i < 8; i++) begin
            bitCyc(1'b1, 0, r);
            d = {d[6:0], r};
        end
        bitCyc(!ackIt, 0, r);
    endtask : readByte
    task automatic stop();
        hold(8);
        sdaDrive <= 1'b0;
        hold(halfCyc);
        scl <= 1'b1;
        hold(halfCyc);
        sdaDrive <= 1'b1;
        hold(halfCyc);
    endtask : stop
endmodule : eps_bus_master

// File: bench/tb.sv
/* self-checking bench for the slave pin block.
   assumes the bus master model and bound checker */
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int UP_CYC = 50;
    localparam int WR_CYC = 6000;
    logic       ref_clk = 1'b0;
    logic       rst     = 1'b1;
    logic [2:0] sel     = 3'h0;
    logic       wp      = 1'b0;
    logic       fp      = 1'b0;
    logic [7:0] rdByte  = 8'h00;
    logic       scl, sdaDrive, sdaOut, sdaOe_n, busSda, wrStrobe, rdStrobe, ready, writeBusy;
    logic [7:0] wrData, lastWr;
    int         failCount = 0, samplesChecked = 0, wrSeen = 0, rdSeen = 0, cycles = 0;
    // wired-and data line with pull-up
    assign busSda = sdaDrive & (sdaOe_n | sdaOut);
    always #4 ref_clk = ~ref_clk;
    eps_slave_pins #(.POWERUP_CYC(UP_CYC), .WRITE_CYC(WR_CYC)) dut (
        .ref_clk(ref_clk), .rst(rst), .serialClock(scl), .serialDataIn(busSda),
        .serialDataOut(sdaOut), .serialDataOe_n(sdaOe_n), .device_select_bit0(sel[0]),
        .device_select_bit1(sel[1]), .device_select_bit2(sel[2]), .writeProtect(wp),
        .fastPlusMode(fp), .rdData(rdByte), .wrData(wrData), .wrStrobe(wrStrobe),
        .rdStrobe(rdStrobe), .ready(ready), .writeBusy(writeBusy));
    eps_bus_master m (.ref_clk(ref_clk), .busSda(busSda), .scl(scl), .sdaDrive(sdaDrive));
    // write and read strobe monitor and hang limit
    always @(posedge ref_clk) begin
        cycles++;
        if (wrStrobe === 1'b1) begin
            wrSeen++;
            lastWr = wrData;
        end
        if (rdStrobe === 1'b1) rdSeen++;
        // all scenarios take about 89000 cycles
        if (cycles > 98000) begin
            failCount++;
            endOfTest();
        end
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            failCount++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic endOfTest();
        if (failCount == 0 && samplesChecked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : endOfTest
    task automatic addrPhase(input logic rw, input logic [2:0] s, output logic a);
        m.start();
        m.sendByte({eps_pkg::DEV_TYPE_CODE, s, rw}, 0, a);
    endtask : addrPhase
    task automatic doReset();
        int n = 0;
        @(posedge ref_clk);
        rst <= 1'b1;
        repeat (20) @(posedge ref_clk);
        #1;
        check({5'h00, sdaOe_n, ready, writeBusy}, 8'h04);
        @(posedge ref_clk);
        rst <= 1'b0;
        while (ready !== 1'b1 && n < 200) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        check(8'(n >= UP_CYC - 2 && n <= UP_CYC + 3), 8'h01);
    endtask : doReset
    task automatic tWrite();
        logic a;
        int n0 = wrSeen;
        int n = 0;
        addrPhase(1'b0, 3'h0, a);
        m.sendByte(8'h01, 0, a);
        m.sendByte(8'h02, 0, a);
        m.sendByte(8'h5a, 0, a);
        check(8'(a), 8'h01);
        m.sendByte(8'ha5, 0, a);
        m.stop();
        #1;
        check(8'(wrSeen - n0), 8'h02);
        check(lastWr, 8'ha5);
        check(8'(writeBusy), 8'h01);
        addrPhase(1'b0, 3'h0, a);
        m.stop();
        check(8'(a), 8'h00);
        while (writeBusy === 1'b1 && n < WR_CYC) begin
            @(posedge ref_clk);
            n++;
        end
        #1;
        check(8'(writeBusy), 8'h00);
    endtask : tWrite
    task automatic tProtect();
        logic a;
        int n0 = wrSeen;
        @(posedge ref_clk);
        wp <= 1'b1;
        addrPhase(1'b0, 3'h0, a);
        m.sendByte(8'h01, 0, a);
        m.sendByte(8'h02, 0, a);
        check(8'(a), 8'h01);
        m.sendByte(8'h5a, 0, a);
        m.stop();
        #1;
        check(8'(a), 8'h00);
        check({7'h00, writeBusy} | 8'(wrSeen - n0), 8'h00);
        @(posedge ref_clk);
        wp <= 1'b0;
    endtask : tProtect
    task automatic tRead();
        logic a;
        logic [7:0] d;
        int r0 = rdSeen;
        @(posedge ref_clk);
        rdByte <= 8'hc3;
        addrPhase(1'b1, 3'h0, a);
        check(8'(a), 8'h01);
        m.readByte(1'b1, d);
        check(d, 8'hc3);
        m.readByte(1'b0, d);
        m.stop();
        check(d, 8'hc3);
        check(8'(rdSeen - r0), 8'h02);
    endtask : tRead
    task automatic tGlitch();
        logic a;
        int gw[4] = '{12, 16, 6, 9};
        for (int i = 0; i < 4; i++) begin
            @(posedge ref_clk);
            fp <= (i >= 2);
            m.halfCyc = (i >= 2) ? 64 : 160;
            m.start();
            m.sendByte({eps_pkg::DEV_TYPE_CODE, 3'h0, 1'b0}, gw[i], a);
            m.stop();
            check(8'(a), 8'(i % 2 == 0));
        end
        @(posedge ref_clk);
        fp <= 1'b0;
        m.halfCyc = 160;
    endtask : tGlitch
    task automatic tMidReset();
        logic a;
        @(posedge ref_clk);
        rdByte <= 8'h3c;
        addrPhase(1'b1, 3'h0, a);
        m.hold(40);
        #1;
        check(8'(sdaOe_n), 8'h00);
        doReset();
        m.stop();
    endtask : tMidReset
    task automatic tSelect();
        logic a;
        for (int i = 0; i < 8; i++) begin
            @(posedge ref_clk);
            sel <= 3'(i);
            addrPhase(1'b0, (i % 2 == 1) ? 3'(i ^ 3) : 3'(i), a);
            m.stop();
            check(8'(a), 8'(i % 2 == 0));
        end
    endtask : tSelect
    // main sequence
    initial begin
        doReset();
        tWrite();
        tProtect();
        tRead();
        tGlitch();
        tMidReset();
        tSelect();
        endOfTest();
    end
endmodule : tb
